// ==== logic/dstc_pkg.sv ====
// package for the display sync timing controller: register indices,
// field positions, write masks and reset values.
// assumes a 32-bit Avalon-MM slave whose address is the register index.
package dstc_pkg;
    localparam int ADDR_W = 6;
    localparam int REG_CNT = 33;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_MODE = 6'h00;
    localparam logic [5:0] IDX_ENABLE = 6'h02;
    localparam logic [5:0] IDX_LINE_TOTAL = 6'h06;
    localparam logic [5:0] IDX_LINE_ACTIVE = 6'h08;
    localparam logic [5:0] IDX_LEFT_PART = 6'h0A;
    localparam logic [5:0] IDX_HPULSE_START = 6'h0C;
    localparam logic [5:0] IDX_HPULSE_WIDTH = 6'h0E;
    localparam logic [5:0] IDX_VPULSE_WIDTH = 6'h0F;
    localparam logic [5:0] IDX_FRAME_TOTAL = 6'h12;
    localparam logic [5:0] IDX_VPULSE_START = 6'h14;
    localparam logic [5:0] IDX_ACTIVE_LINES = 6'h16;
    localparam logic [5:0] IDX_WIN_LEFT = 6'h18;
    localparam logic [5:0] IDX_WIN_TOP = 6'h1A;
    localparam logic [5:0] IDX_WIN_PIXELS = 6'h1C;
    localparam logic [5:0] IDX_WIN_RASTERS = 6'h1E;
    localparam logic [5:0] IDX_CONSOLE = 6'h20;
    localparam logic [5:0] IDX_STATUS = 6'h3E;
    localparam logic [5:0] IDX_SOFT_RESET = 6'h3F;
    // display_mode_reg fields
    localparam int MODE_SCAN_LSB = 0;
    localparam int MODE_LOCK_BIT = 2;
    localparam int MODE_POL_BIT = 3;
    localparam int MODE_PARITY_BIT = 5;
    localparam int MODE_DIV_LSB = 8;
    localparam int MODE_SRC_BIT = 15;
    localparam logic [1:0] SCAN_INTERLACED = 2'h3;
    // display_enable_reg fields
    localparam int EN_CONSOLE_BIT = 0;
    localparam int EN_WINDOW_BIT = 1;
    localparam int EN_MIDDLE_BIT = 2;
    localparam int EN_BASE_BIT = 3;
    localparam int EN_OUTPUT_BIT = 15;
    // console_layout_reg fields
    localparam int CON_HEIGHT_LSB = 0;
    localparam int CON_STRIDE_LSB = 16;
    localparam int CON_COLOR_BIT = 31;
    localparam int CON_STRIDE_SHIFT = 6;
    // reset values and writable masks
    localparam logic [31:0] MODE_RESET = 32'h0000_1E00;
    localparam logic [31:0] MASK_MODE = 32'h0000_9F2F;
    localparam logic [31:0] MASK_ENABLE = 32'h0000_800F;
    localparam logic [31:0] MASK_FIELD12 = 32'h0000_0FFF;
    localparam logic [31:0] MASK_BYTE = 32'h0000_00FF;
    localparam logic [31:0] MASK_VWIDTH = 32'h0000_003F;
    localparam logic [31:0] MASK_CONSOLE = 32'h80FF_0FFF;
endpackage

// ==== logic/dstc_display_sync_timing.sv ====
// display sync timing controller: dot clock, line and raster counters,
// sync pulses, field parity, layer gating, window and console geometry.
// assumes ref_clk stands for the internal PLL output; external dot clock
// and sync pins are asynchronous and are synchronised here.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
// What this block does
// - scan field: bit 0 clear is progressive, 11 is interlaced
// - lock counters to external sync inputs only when lock bit is set
// - sync outputs active low for polarity 0, active high for 1
// - parity output low even, high odd; inverted when its bit is set
// - dot clock is source divided by divider plus one; reset 11110
// - source is internal clock at 0, external dot clock pin at 1
// - software reset leaves the display mode register untouched
// - console, window, middle, base layers shown only when enabled
// - no display signal output while output enable bit is 0
// - each line lasts line total plus one dot clocks
// - active display is line active plus one pixel clocks
// - left partition lasts boundary plus one; software sets it if unsplit
// - hsync asserts when dot count reaches pulse start
// - hsync lasts pulse width plus one dot clocks
// - vsync lasts six-bit width plus one rasters
// - frame is total plus one rasters; interlaced field plus 1.5
// - vsync starts on raster vertical position
// - active lines plus one rasters displayed per frame
// - window edges placed at programmed dot and raster offsets
// - window width from pixel count; software never writes zero
// - window height is setting plus one rasters
// - console height bits 11-0 plus one; stride bits 23-16 times 64
// - console pixels are 8-bit lookup colour when colour bit is 0
// - console pixels are 16-bit direct colour when colour bit is 1
module dstc_display_sync_timing
    import dstc_pkg::*;
#(
    parameter int CNT_W = 12
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // avalon-mm slave
    input wire logic [dstc_pkg::ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // external pins, asynchronous
    input wire logic extDotClockIn,
    input wire logic extHsyncIn,
    input wire logic extVsyncIn,
    // video outputs
    output logic hsyncOut,
    output logic vsyncOut,
    output logic csyncOut,
    output logic parityOut,
    output logic displayActive,
    output logic leftPartition,
    output logic dotTick,
    // layer gating and window
    output logic consoleShow,
    output logic windowShow,
    output logic middleShow,
    output logic baseShow,
    // console geometry
    output logic consoleDirectColor,
    output logic [13:0] consoleLineBytes,
    output logic [12:0] consoleFrameLines
);
    import dstc_pkg::*;

    logic [31:0] regs [0:REG_CNT-1];
    logic busAck;
    logic softReset;
    logic run;
    logic extClk1, extClk2, extClk3;
    logic extHs1, extHs2, extHs3;
    logic extVs1, extVs2, extVs3;
    logic srcTick, extHsEdge, extVsEdge, halfStep, lineWrap;
    logic [4:0] divCnt;
    logic [CNT_W-1:0] hCount;
    logic [CNT_W+1:0] vHalf;
    logic [CNT_W+1:0] fieldEnd;
    logic [CNT_W:0] raster;
    logic [CNT_W:0] halfSum;
    logic oddField;
    logic hsOn, vsOn, hAct, vAct, winOn;

    // byte lanes turned into a bit mask
    function automatic logic [31:0] laneMask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // writable bits of each index; zero marks an unmapped word
    function automatic logic [31:0] wrMask(input logic [5:0] idx);
        unique case (idx)
            IDX_MODE: return MASK_MODE;
            IDX_ENABLE: return MASK_ENABLE;
            IDX_HPULSE_WIDTH: return MASK_BYTE;
            IDX_VPULSE_WIDTH: return MASK_VWIDTH;
            IDX_CONSOLE: return MASK_CONSOLE;
            IDX_LINE_TOTAL, IDX_LINE_ACTIVE, IDX_LEFT_PART,
            IDX_HPULSE_START, IDX_FRAME_TOTAL, IDX_VPULSE_START,
            IDX_ACTIVE_LINES, IDX_WIN_LEFT, IDX_WIN_TOP,
            IDX_WIN_PIXELS, IDX_WIN_RASTERS: return MASK_FIELD12;
            default: return 32'h0000_0000;
        endcase
    endfunction

    // one wait state on every access: answer is taken on the second edge
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            busAck <= 1'b0;
        end else begin
            busAck <= (read || write) && !busAck;
        end
    end
    assign waitrequest = (read || write) && !busAck;

    // register file; unmapped words keep zero and ignore writes
    genvar gi;
    generate
        for (gi = 0; gi < REG_CNT; gi++) begin : g_reg
            localparam logic [5:0] IDX = 6'(gi);
            always_ff @(posedge ref_clk or negedge rst_b) begin
                if (!rst_b) begin
                    regs[gi] <= (IDX == IDX_MODE) ? MODE_RESET : 32'h0000_0000;
                end else if (softReset && IDX != IDX_MODE) begin
                    regs[gi] <= 32'h0000_0000;
                end else if (write && busAck && address == IDX) begin
                    regs[gi] <= (regs[gi] & ~(wrMask(IDX) & laneMask(byteenable)))
                        | (writedata & wrMask(IDX) & laneMask(byteenable));
                end
            end
        end
    endgenerate

    // soft reset is a one-cycle pulse from a write of bit 0
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            softReset <= 1'b0;
        end else begin
            softReset <= write && busAck && address == IDX_SOFT_RESET
                && byteenable[0] && writedata[0];
        end
    end

    // read data is latched on the first cycle and stands at the accept edge
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            readdata <= 32'h0000_0000;
        end else if (read && !busAck) begin
            if (address == IDX_STATUS) begin
                readdata <= {12'h000, oddField, vsOn, hsOn, run,
                             3'b000, raster};
            end else if (address < 6'(REG_CNT)) begin
                readdata <= regs[address] & wrMask(address);
            end else begin
                readdata <= 32'h0000_0000;
            end
        end
    end

    // field views of the registers
    wire logic [31:0] modeReg = regs[IDX_MODE];
    wire logic [31:0] enReg = regs[IDX_ENABLE];
    wire logic [31:0] conReg = regs[IDX_CONSOLE];
    wire logic interlaced =
        modeReg[MODE_SCAN_LSB +: 2] == SCAN_INTERLACED;
    wire logic lockOn = modeReg[MODE_LOCK_BIT];
    wire logic pol = modeReg[MODE_POL_BIT];
    wire logic eoPol = modeReg[MODE_PARITY_BIT];
    wire logic [4:0] divider = modeReg[MODE_DIV_LSB +: 5];
    wire logic srcExt = modeReg[MODE_SRC_BIT];
    wire logic [CNT_W-1:0] lineTotal = regs[IDX_LINE_TOTAL][CNT_W-1:0];
    wire logic [CNT_W-1:0] lineActive = regs[IDX_LINE_ACTIVE][CNT_W-1:0];
    wire logic [CNT_W-1:0] leftWidth = regs[IDX_LEFT_PART][CNT_W-1:0];
    wire logic [CNT_W-1:0] hpulse_start = regs[IDX_HPULSE_START][CNT_W-1:0];
    wire logic [7:0] hpulse_width = regs[IDX_HPULSE_WIDTH][7:0];
    wire logic [5:0] vpulse_width = regs[IDX_VPULSE_WIDTH][5:0];
    wire logic [CNT_W-1:0] frame_total_lines = regs[IDX_FRAME_TOTAL][CNT_W-1:0];
    wire logic [CNT_W-1:0] vpulse_start = regs[IDX_VPULSE_START][CNT_W-1:0];
    wire logic [CNT_W-1:0] active_lines = regs[IDX_ACTIVE_LINES][CNT_W-1:0];
    wire logic [CNT_W-1:0] wx = regs[IDX_WIN_LEFT][CNT_W-1:0];
    wire logic [CNT_W-1:0] wy = regs[IDX_WIN_TOP][CNT_W-1:0];
    wire logic [CNT_W-1:0] ww = regs[IDX_WIN_PIXELS][CNT_W-1:0];
    wire logic [CNT_W-1:0] wh = regs[IDX_WIN_RASTERS][CNT_W-1:0];

    assign run = enReg[EN_OUTPUT_BIT] && !softReset;

    // pin synchronisers; only the second and third stages are looked at
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            {extClk1, extClk2, extClk3} <= 3'b000;
            {extHs1, extHs2, extHs3} <= 3'b000;
            {extVs1, extVs2, extVs3} <= 3'b000;
        end else begin
            {extClk1, extClk2, extClk3} <= {extDotClockIn, extClk1, extClk2};
            {extHs1, extHs2, extHs3} <= {extHsyncIn, extHs1, extHs2};
            {extVs1, extVs2, extVs3} <= {extVsyncIn, extVs1, extVs2};
        end
    end

    // source is one tick per ref_clk or one per external rising edge
    assign srcTick = srcExt ? (extClk2 && !extClk3) : 1'b1;
    // external pulses are read at the programmed active level
    assign extHsEdge = lockOn && ((extHs2 ^ ~pol) && !(extHs3 ^ ~pol));
    assign extVsEdge = lockOn && ((extVs2 ^ ~pol) && !(extVs3 ^ ~pol));

    // dot clock prescaler; a divider of 0 passes every source tick
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            divCnt <= 5'h00;
        end else if (!run) begin
            divCnt <= 5'h00;
        end else if (srcTick) begin
            divCnt <= (divCnt == divider) ? 5'h00 : divCnt + 5'h01;
        end
    end
    assign dotTick = run && srcTick && divCnt == divider;

    // horizontal counter; 0 is the first dot of the display period
    assign lineWrap = dotTick && hCount == lineTotal;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            hCount <= '0;
        end else if (!run) begin
            hCount <= '0;
        end else if (extHsEdge) begin
            hCount <= hpulse_start;
        end else if (dotTick) begin
            hCount <= lineWrap ? '0 : hCount + 1'b1;
        end
    end

    // the raster counter runs in half lines so an interlaced field can
    // end mid-line; a progressive field always holds an even count
    assign halfSum = {1'b0, lineTotal} + 1'b1;
    assign halfStep = lineWrap
        || (dotTick && hCount + 1'b1 == halfSum[CNT_W:1]);
    assign fieldEnd = interlaced ? {1'b0, frame_total_lines, 1'b0} + 2'd2
                                 : {1'b0, frame_total_lines, 1'b0} + 2'd1;
    assign raster = vHalf[CNT_W+1:1];

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            vHalf <= '0;
        end else if (!run) begin
            vHalf <= '0;
        end else if (extVsEdge) begin
            vHalf <= {1'b0, vpulse_start, 1'b0};
        end else if (halfStep) begin
            vHalf <= (vHalf == fieldEnd) ? '0 : vHalf + 1'b1;
        end
    end

    // field parity flips at every field end in interlaced scan only
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            oddField <= 1'b0;
        end else if (!run || !interlaced) begin
            oddField <= 1'b0;
        end else if (halfStep && vHalf == fieldEnd) begin
            oddField <= !oddField;
        end
    end

    // beat decodes; differences are taken only once the minimum is passed
    always_comb begin
        hsOn = hCount >= hpulse_start
            && CNT_W'(hCount - hpulse_start) <= CNT_W'(hpulse_width);
        vsOn = raster >= {1'b0, vpulse_start}
            && (CNT_W+1)'(raster - vpulse_start) <= (CNT_W+1)'(vpulse_width);
        hAct = hCount <= lineActive;
        vAct = raster <= {1'b0, active_lines};
        winOn = hCount >= wx && CNT_W'(hCount - wx) < ww
            && raster >= {1'b0, wy}
            && (CNT_W+1)'(raster - wy) <= {1'b0, wh};
    end

    // video outputs; with output disabled all sit at their idle level
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            hsyncOut <= 1'b1;
            vsyncOut <= 1'b1;
            csyncOut <= 1'b1;
            parityOut <= 1'b0;
            displayActive <= 1'b0;
            leftPartition <= 1'b0;
        end else begin
            hsyncOut <= ~((run && hsOn) ^ pol);
            vsyncOut <= ~((run && vsOn) ^ pol);
            csyncOut <= ~((run && (hsOn || vsOn)) ^ pol);
            parityOut <= run && (oddField ^ eoPol);
            displayActive <= run && hAct && vAct;
            leftPartition <= run && vAct
                && hCount <= leftWidth;
        end
    end

    // layer gating follows the active area of the frame
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            consoleShow <= 1'b0;
            windowShow <= 1'b0;
            middleShow <= 1'b0;
            baseShow <= 1'b0;
        end else begin
            consoleShow <= run && hAct && vAct && enReg[EN_CONSOLE_BIT];
            windowShow <= run && hAct && vAct && winOn
                && enReg[EN_WINDOW_BIT];
            middleShow <= run && hAct && vAct && enReg[EN_MIDDLE_BIT];
            baseShow <= run && hAct && vAct && enReg[EN_BASE_BIT];
        end
    end

    // console frame geometry for the fetch engine
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            consoleDirectColor <= 1'b0;
            consoleLineBytes <= 14'h0000;
            consoleFrameLines <= 13'h0000;
        end else begin
            consoleDirectColor <= conReg[CON_COLOR_BIT];
            consoleLineBytes <= {conReg[CON_STRIDE_LSB +: 8], 6'h00};
            consoleFrameLines <= {1'b0, conReg[CON_HEIGHT_LSB +: 12]}
                + 13'h0001;
        end
    end

    // checks
    sequence s_busReq;
        (read || write) && waitrequest;
    endsequence

    sequence s_lineEnd;
        run && lineWrap && !extHsEdge;
    endsequence

    chk_bus_one_wait: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_busReq |=> !waitrequest)
        else $error("access not answered after one wait state");

    chk_line_wrap_zero: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        s_lineEnd ##1 run |-> hCount == '0)
        else $error("line did not wrap after line total");

    chk_hsync_start_level: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        run && hCount == hpulse_start && $stable(pol) |=> hsyncOut == pol)
        else $error("hsync not active at pulse start");

    chk_hsync_end_level: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        run && hCount == hpulse_start + hpulse_width + 1'b1 && hCount >= hpulse_start
        && $stable(pol) |=> hsyncOut == !pol)
        else $error("hsync held beyond width plus one");

    chk_vsync_start_level: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        run && raster == {1'b0, vpulse_start} |=> vsyncOut == $past(pol))
        else $error("vsync not active on its raster");

    chk_disabled_idle: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        !run |=> hsyncOut == !$past(pol) && !displayActive && !consoleShow
        && !windowShow && !parityOut)
        else $error("display signal while output disabled");

    chk_field_wrap_zero: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        run && halfStep && vHalf == fieldEnd && !extVsEdge ##1 run
        |-> vHalf == '0)
        else $error("field did not end at its total");

    chk_softrst_mode_kept: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        softReset |=> modeReg == $past(modeReg) && enReg == 32'h0000_0000)
        else $error("software reset disturbed the mode register");

    chk_parity_level_out: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        run && !interlaced ##1 run |-> parityOut == $past(eoPol))
        else $error("parity output wrong in progressive scan");

    chk_layer_gate_on: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        consoleShow || baseShow |-> displayActive
        && ($past(enReg[EN_CONSOLE_BIT]) || $past(enReg[EN_BASE_BIT])))
        else $error("layer shown without its enable");

    chk_divider_gap: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        dotTick && !srcExt && divider == 5'h01 && $stable(modeReg)
        ##1 run [*2] |-> dotTick && !$past(dotTick))
        else $error("dot clock period not divider plus one");
endmodule

// ==== bench/dstc_sink_model.sv ====
// far-side sink: measures sync period and active width in ref_clk cycles.
// assumes registered sync outputs; external pins are held idle here.
`timescale 1ns/100ps
module dstc_sink_model (
    // clock and expected active level
    input wire logic ref_clk,
    input wire logic pol,
    // syncs from the block
    input wire logic hsyncOut,
    input wire logic vsyncOut,
    // external pins: clock stands still, syncs idle, so no lock
    output logic extDotClockIn,
    output logic extHsyncIn,
    output logic extVsyncIn,
    // measurements
    output int hPer,
    output int hWid,
    output int vPer,
    output int vWid
);
    logic hL = 1'b0;
    logic vL = 1'b0;
    int hA = 0;
    int hW = 0;
    int vA = 0;
    int vW = 0;
    assign extDotClockIn = 1'b0;
    assign extHsyncIn = !pol;
    assign extVsyncIn = !pol;
    // period counts from one active start to the next
    always @(posedge ref_clk) begin
        hL <= hsyncOut;
        vL <= vsyncOut;
        hA <= hA + 1;
        vA <= vA + 1;
        hW <= (hsyncOut == pol) ? hW + 1 : 0;
        vW <= (vsyncOut == pol) ? vW + 1 : 0;
        if (hsyncOut == pol && hL != pol) begin
            hPer <= hA;
            hA <= 1;
        end
        if (vsyncOut == pol && vL != pol) begin
            vPer <= vA;
            vA <= 1;
        end
        if (hsyncOut != pol && hL == pol) hWid <= hW;
        if (vsyncOut != pol && vL == pol) vWid <= vW;
    end
endmodule

// ==== bench/tb_display_sync_timing_ctrl.sv ====
// testbench: register model over avalon-mm, sync timing via the sink.
// assumes the package indices and masks describe the register file.
`timescale 1ns/100ps
module tb_display_sync_timing_ctrl;
    import dstc_pkg::*;
    logic ref_clk = 0, rst_b = 0, read = 0, write = 0, pol = 0;
    logic [5:0] address = 0;
    logic [31:0] writedata = 0, readdata, rd;
    logic [3:0] byteenable = 4'hF;
    logic waitrequest, hsyncOut, vsyncOut, csyncOut, parityOut;
    logic displayActive, leftPartition, dotTick, consoleShow, windowShow;
    logic middleShow, baseShow, consoleDirectColor;
    logic extDotClockIn, extHsyncIn, extVsyncIn;
    logic [13:0] consoleLineBytes;
    logic [12:0] consoleFrameLines;
    logic [31:0] mdl [64];
    int hPer, hWid, vPer, vWid, failures = 0, samples_checked = 0;
    int seed = 32'hed3c;
    dstc_display_sync_timing i_dstc_display_sync_timing (.ref_clk, .rst_b,
        .address, .read, .write, .writedata, .byteenable, .readdata,
        .waitrequest, .extDotClockIn, .extHsyncIn, .extVsyncIn, .hsyncOut,
        .vsyncOut, .csyncOut, .parityOut, .displayActive, .leftPartition,
        .dotTick, .consoleShow, .windowShow, .middleShow, .baseShow,
        .consoleDirectColor, .consoleLineBytes, .consoleFrameLines);
    dstc_sink_model i_dstc_sink_model (.ref_clk, .pol, .hsyncOut,
        .vsyncOut, .extDotClockIn, .extHsyncIn, .extVsyncIn, .hPer, .hWid,
        .vPer, .vWid);
    initial begin
        forever #10 ref_clk = !ref_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] mask(input logic [5:0] a);
        case (a)
            IDX_MODE: return MASK_MODE;
            IDX_ENABLE: return MASK_ENABLE;
            IDX_HPULSE_WIDTH: return MASK_BYTE;
            IDX_VPULSE_WIDTH: return MASK_VWIDTH;
            IDX_CONSOLE: return MASK_CONSOLE;
            IDX_LINE_TOTAL, IDX_LINE_ACTIVE, IDX_LEFT_PART, IDX_HPULSE_START,
            IDX_FRAME_TOTAL, IDX_VPULSE_START, IDX_ACTIVE_LINES, IDX_WIN_LEFT,
            IDX_WIN_TOP, IDX_WIN_PIXELS, IDX_WIN_RASTERS: return MASK_FIELD12;
            default: return 32'h0000_0000;
        endcase
    endfunction
    // request held until the rising edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        @(posedge ref_clk);
        while (waitrequest !== 1'b0) @(posedge ref_clk);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (wr) mdl[a] = d & mask(a);
    endtask
    task automatic sweep;
        for (int a = 0; a <= 32; a++) begin
            bus(1'b0, a[5:0], 32'h0000_0000);
            check(rd, mdl[a]);
        end
    endtask
    // program a raster, enable, measure over 4000 ref_clk cycles, then disable
    task automatic run(input logic [31:0] mode, input logic [31:0] en,
                       input int lt, input int hpulse_width, input int frame_total_lines,
                       input int vpulse_width, input int dv, input int vp);
        bus(1'b1, IDX_LINE_TOTAL, lt);
        bus(1'b1, IDX_LINE_ACTIVE, lt - 12);
        bus(1'b1, IDX_LEFT_PART, lt - 12);
        bus(1'b1, IDX_HPULSE_START, lt - 8);
        bus(1'b1, IDX_HPULSE_WIDTH, hpulse_width);
        bus(1'b1, IDX_FRAME_TOTAL, frame_total_lines);
        bus(1'b1, IDX_ACTIVE_LINES, frame_total_lines - 4);
        bus(1'b1, IDX_VPULSE_START, frame_total_lines - 2);
        bus(1'b1, IDX_VPULSE_WIDTH, vpulse_width);
        // window spans the whole line and frame so its gate follows enable
        bus(1'b1, IDX_WIN_PIXELS, lt + 1);
        bus(1'b1, IDX_WIN_RASTERS, frame_total_lines);
        bus(1'b1, IDX_MODE, mode);
        pol = mode[MODE_POL_BIT];
        bus(1'b1, IDX_ENABLE, en);
        repeat (4000) @(posedge ref_clk);
        check(hPer, (lt + 1) * dv);
        check(hWid, (hpulse_width + 1) * dv);
        check(vPer, vp);
        check(vWid, (vpulse_width + 1) * (lt + 1) * dv);
        // layer gates only show inside the active area
        @(posedge ref_clk iff displayActive === 1'b1);
        check(leftPartition, 1'b1);
        check({consoleShow, windowShow, middleShow, baseShow},
              {en[0], en[1], en[2], en[3]});
        if (!mode[0]) check(parityOut, mode[MODE_PARITY_BIT]);
        bus(1'b1, IDX_ENABLE, 32'h0000_000F);
        repeat (3) @(posedge ref_clk);
        check({hsyncOut, vsyncOut, csyncOut, consoleShow, displayActive},
              {!pol, !pol, !pol, 1'b0, 1'b0});
    endtask
    task automatic results;
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #400_000;
        failures++;
        results();
    end
    initial begin
        foreach (mdl[i]) mdl[i] = 32'h0000_0000;
        mdl[IDX_MODE] = MODE_RESET;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        sweep();
        for (int a = 0; a <= 32; a++) begin
            bus(1'b1, a[5:0], $random(seed));
        end
        sweep();
        bus(1'b1, IDX_SOFT_RESET, 32'h0000_0001);
        for (int a = 1; a <= 32; a++) mdl[a] = 32'h0000_0000;
        sweep();
        run(32'h0000_0028, 32'h0000_800F, 39, 3, 9, 1, 1, 400);
        run(32'h0000_0103, 32'h0000_8005, 39, 3, 9, 1, 2, 840);
        bus(1'b1, IDX_CONSOLE, 32'h8012_0ABC);
        repeat (2) @(posedge ref_clk);
        check(consoleFrameLines, 13'h0ABD);
        check(consoleLineBytes, 14'h0480);
        check(consoleDirectColor, 1'b1);
        bus(1'b1, IDX_CONSOLE, 32'h0003_0005);
        repeat (2) @(posedge ref_clk);
        check({consoleDirectColor, consoleLineBytes}, 15'h00C0);
        results();
    end
endmodule
